/* File: rtl/rcc_consts.svh */
// register offsets, field positions, reset values and timing counts of the reset cause block
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH

// ----------------------------------------------------------------
// register map (byte offsets from the reset block base)
// ----------------------------------------------------------------
`define RCC_BASE_ADDR 32'h4000_2400
`define RCC_CAUSE_OFS 12'h040
`define RCC_IRQ_STAT_OFS 12'h044
`define RCC_IRQ_MASK_OFS 12'h048
`define RCC_SRC_LEVEL_OFS 12'h04C

// ----------------------------------------------------------------
// field positions of the cause, irq status and irq mask registers
// ----------------------------------------------------------------
`define RCC_BIT_POR 0
`define RCC_BIT_PIN 1
`define RCC_BIT_WDT 2
`define RCC_BIT_SW 3
`define RCC_NUM_SRC 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RCC_CAUSE_POR_INIT 8'h01
`define RCC_IRQ_STAT_RST 4'h0
`define RCC_IRQ_MASK_RST 4'h0
`define RCC_RDATA_RST 32'h0000_0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RCC_CLK_PERIOD_NS 10
`define RCC_ACCESS_CYCLES 3
`define RCC_HOLD_NS 160
`define RCC_HOLD_CYCLES ((`RCC_HOLD_NS + `RCC_CLK_PERIOD_NS - 1) / `RCC_CLK_PERIOD_NS)
`define RCC_PIN_FILTER_NS 40
`define RCC_PIN_FILTER_CYCLES \
    ((`RCC_PIN_FILTER_NS + `RCC_CLK_PERIOD_NS - 1) / `RCC_CLK_PERIOD_NS)

`endif

/* File: rtl/rcc_pkg.sv */
// types shared by the reset cause block
package rcc_pkg;

    typedef logic [11:0] rcc_addr_t;
    typedef logic [31:0] rcc_data_t;
    typedef logic [3:0] rcc_src_t;

    // gray steps idle -> assert -> release; release -> idle flips both bits
    typedef enum logic [1:0] {
        RCC_IDLE = 2'b00,
        RCC_ASSERT = 2'b01,
        RCC_RELEASE = 2'b11
    } rcc_hold_state_t;

endpackage

/* File: rtl/rcc_sync2.sv */
// two flip-flop synchroniser for the pin reset and power-on indications
`timescale 1ns/1ps

module rcc_sync2 (
    // clock
    input wire logic core_clk,
    // asynchronous inputs and synchronised copies
    input wire logic [1:0] async_in,
    output logic [1:0] sync_out
);

    logic [1:0] meta_ff;
    logic [1:0] stable_ff;

    // no reset: the power-on indication itself passes through here
    always_ff @(posedge core_clk) begin
        meta_ff <= async_in;
        stable_ff <= meta_ff;
    end

    assign sync_out = stable_ff;

endmodule

/* File: rtl/rcc_top.sv */
// reset cause capture: records the source of the last reset and holds it for software
//
// Summary of operation
// RL1 - four reset sources: software request, external pin, power-on, watchdog timeout.
// RL2 - software reset is requested by the core writing its reset control key.
// RL3 - recorded cause flags stay unchanged until software clears them.
// RL4 - software reset sets bit 3; watchdog timeout sets bit 2.
// RL5 - external pin reset sets bit 1; power-on reset sets bit 0.
// RL6 - writing one to a clear bit zeroes the matching cause flag.
// RL7 - status and clear share offset 0x0040; reads status, writes clear.
// RL8 - status after reset reflects the most recent reset source.
// RL9 - external pin reset leaves the debug logic untouched.
// RL10 - a register access takes three cycles of the block clock.
// RL11 - software polls causes after reset and treats surprises as faults.
// RL12 - clear bits written zero change nothing; bits 7 to 4 read zero.
// RL13 - power-on leaves only the power-on flag; others add their flag.
`timescale 1ns/1ps
`include "rcc_consts.svh"

module rcc_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // reset sources
    input wire logic sw_reset_req,
    input wire logic wdt_timeout,
    input wire logic pin_reset_n,
    input wire logic por_in,
    // register port
    input wire rcc_pkg::rcc_addr_t reg_addr,
    input wire rcc_pkg::rcc_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output rcc_pkg::rcc_data_t reg_rdata,
    // reset outputs
    output logic sys_reset_out,
    output logic debug_reset_out,
    // interrupt
    output logic irq
);
    import rcc_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic addr_hit(input rcc_addr_t addr, input rcc_addr_t ofs);
        addr_hit = (addr == ofs);
    endfunction

    function automatic rcc_src_t w1c(input rcc_src_t cur, input rcc_src_t clr,
                                     input rcc_src_t set);
        // set wins over a clear landing in the same cycle
        w1c = (cur & ~clr) | set;
    endfunction

    localparam int HOLD_CYCLES = `RCC_HOLD_CYCLES;
    localparam int PIN_FILTER_CYCLES = `RCC_PIN_FILTER_CYCLES;
    localparam int CLR_STAGES = `RCC_ACCESS_CYCLES - 1;
    localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYCLES - 1);
    localparam logic [7:0] PIN_LAST = 8'(PIN_FILTER_CYCLES - 1);

    // ----------------------------------------------------------------
    // synchronise the pin and power-on inputs
    // ----------------------------------------------------------------
    logic [1:0] sync_lvl;
    logic pin_low_s;
    logic por_s;

    // the raw pins go straight into the flops; the pin is inverted only once it is clean
    rcc_sync2 u_sync (
        .core_clk(core_clk),
        .async_in({por_in, pin_reset_n}),
        .sync_out(sync_lvl)
    );

    assign pin_low_s = ~sync_lvl[0];
    assign por_s = sync_lvl[1];

    // ----------------------------------------------------------------
    // source event detection
    // ----------------------------------------------------------------
    logic por_d_ff;
    logic por_event;
    logic [7:0] pin_cnt_ff;
    logic pin_seen_ff;
    logic pin_event;
    rcc_src_t src_event;

    always_ff @(posedge core_clk) begin
        por_d_ff <= por_s;
    end

    assign por_event = por_s & ~por_d_ff;

    // ----------------------------------------------------------------
    // pin reset filter
    // ----------------------------------------------------------------
    // the pin must stay low for the filter time; a glitch shorter than that is no reset
    always_ff @(posedge core_clk) begin
        if (por_s || !pin_low_s) begin
            pin_cnt_ff <= 8'h00;
            pin_seen_ff <= 1'b0;
        end else if (!pin_seen_ff) begin
            if (pin_cnt_ff == PIN_LAST) begin
                pin_seen_ff <= 1'b1;
            end else begin
                pin_cnt_ff <= pin_cnt_ff + 8'h01;
            end
        end
    end

    assign pin_event = pin_low_s && !pin_seen_ff && (pin_cnt_ff == PIN_LAST) && !por_s;

    // ----------------------------------------------------------------
    // source vector
    // ----------------------------------------------------------------
    // one bit per source, laid out as in the cause register (see RL1)
    always_comb begin
        src_event = 4'h0;
        src_event[`RCC_BIT_POR] = por_event;
        src_event[`RCC_BIT_PIN] = pin_event;
        src_event[`RCC_BIT_WDT] = wdt_timeout & ~por_s;
        src_event[`RCC_BIT_SW] = sw_reset_req & ~por_s;
    end

    // ----------------------------------------------------------------
    // register port decode
    // ----------------------------------------------------------------
    logic wr_cause;
    logic wr_irq_stat;
    logic wr_irq_mask;

    assign wr_cause = reg_wr && addr_hit(reg_addr, `RCC_CAUSE_OFS); // see RL7
    assign wr_irq_stat = reg_wr && addr_hit(reg_addr, `RCC_IRQ_STAT_OFS);
    assign wr_irq_mask = reg_wr && addr_hit(reg_addr, `RCC_IRQ_MASK_OFS);

    // ----------------------------------------------------------------
    // clear pipeline: a clear write lands after the access time
    // ----------------------------------------------------------------
    rcc_src_t clr_stage_ff [CLR_STAGES];
    rcc_src_t clr_apply;
    rcc_src_t clr_bits;

    // bits 7..4 of the write are dropped here (see RL12)
    assign clr_bits = wr_cause ? reg_wdata[3:0] : 4'h0;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < CLR_STAGES; i++) begin
                clr_stage_ff[i] <= 4'h0;
            end
        end else begin
            clr_stage_ff[0] <= clr_bits; // see RL10
            for (int i = 1; i < CLR_STAGES; i++) begin
                clr_stage_ff[i] <= clr_stage_ff[i - 1];
            end
        end
    end

    assign clr_apply = clr_stage_ff[CLR_STAGES - 1];

    // ----------------------------------------------------------------
    // reset cause register
    // ----------------------------------------------------------------
    rcc_src_t cause_ff;
    rcc_src_t nxt_cause;

    // the stored field is four bits wide; bits 7..4 of the register are tied to zero
    localparam rcc_src_t POR_ONLY = rcc_src_t'(`RCC_CAUSE_POR_INIT);

    // only power-on rebuilds the cause; srst must not wipe the record it describes
    always_comb begin
        if (por_s) begin
            nxt_cause = POR_ONLY; // see RL13 see RL8 see RL5
        end else begin
            // zero bits in the clear leave flags alone (see RL6 see RL12)
            nxt_cause = w1c(cause_ff, clr_apply, src_event); // see RL3 see RL4 see RL13
        end
    end

    always_ff @(posedge core_clk) begin
        cause_ff <= nxt_cause;
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    rcc_src_t irq_stat_ff;
    rcc_src_t irq_mask_ff;
    rcc_src_t irq_clr_bits;
    logic irq_ff;

    assign irq_clr_bits = wr_irq_stat ? reg_wdata[3:0] : 4'h0;

    // events arriving in a reset cycle still land, so the cause is not lost
    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_stat_ff <= `RCC_IRQ_STAT_RST | src_event;
        end else begin
            irq_stat_ff <= w1c(irq_stat_ff, irq_clr_bits, src_event); // see RL6
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_mask_ff <= `RCC_IRQ_MASK_RST;
        end else if (wr_irq_mask) begin
            irq_mask_ff <= reg_wdata[3:0];
        end
    end

    // ----------------------------------------------------------------
    // interrupt output
    // ----------------------------------------------------------------
    // registered, so the line lags a status or mask change by one cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    assign irq = irq_ff;

    // ----------------------------------------------------------------
    // system reset hold sequencer
    // ----------------------------------------------------------------
    rcc_hold_state_t state_ff;
    rcc_hold_state_t nxt_state;
    logic [7:0] hold_cnt_ff;
    logic [7:0] nxt_hold_cnt;
    logic any_event;

    assign any_event = |src_event[`RCC_BIT_SW:`RCC_BIT_PIN] || por_s;

    always_comb begin
        nxt_state = state_ff;
        nxt_hold_cnt = hold_cnt_ff;
        case (state_ff)
            RCC_IDLE: begin
                if (any_event) begin
                    nxt_state = RCC_ASSERT;
                    nxt_hold_cnt = 8'h00;
                end
            end
            RCC_ASSERT: begin
                if (any_event) begin
                    // a fresh source restarts the hold time
                    nxt_hold_cnt = 8'h00;
                end else if (hold_cnt_ff == HOLD_LAST) begin
                    nxt_state = RCC_RELEASE;
                end else begin
                    nxt_hold_cnt = hold_cnt_ff + 8'h01;
                end
            end
            RCC_RELEASE: begin
                nxt_state = any_event ? RCC_ASSERT : RCC_IDLE;
                nxt_hold_cnt = 8'h00;
            end
            default: begin
                nxt_state = RCC_IDLE;
                nxt_hold_cnt = 8'h00;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_ff <= RCC_IDLE;
            hold_cnt_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            hold_cnt_ff <= nxt_hold_cnt;
        end
    end

    // ----------------------------------------------------------------
    // system reset output
    // ----------------------------------------------------------------
    logic sys_reset_ff;

    // taken from the next state so the output carries no decode glitch
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sys_reset_ff <= 1'b0;
        end else begin
            sys_reset_ff <= (nxt_state == RCC_ASSERT);
        end
    end

    assign sys_reset_out = sys_reset_ff;

    // ----------------------------------------------------------------
    // debug reset follows power-on only
    // ----------------------------------------------------------------
    logic debug_reset_ff;

    // pin, watchdog and software resets never reach the debug logic (see RL9)
    always_ff @(posedge core_clk) begin
        debug_reset_ff <= por_s;
    end

    assign debug_reset_out = debug_reset_ff;

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    rcc_data_t nxt_rdata;
    rcc_data_t rdata_ff;

    always_comb begin
        nxt_rdata = `RCC_RDATA_RST;
        if (reg_rd) begin
            case (reg_addr)
                // upper bits read zero (see RL12 see RL7)
                `RCC_CAUSE_OFS: nxt_rdata = {28'h000_0000, cause_ff};
                `RCC_IRQ_STAT_OFS: nxt_rdata = {28'h000_0000, irq_stat_ff};
                `RCC_IRQ_MASK_OFS: nxt_rdata = {28'h000_0000, irq_mask_ff};
                `RCC_SRC_LEVEL_OFS: begin
                    nxt_rdata = {28'h000_0000, sys_reset_ff, debug_reset_ff,
                                 pin_low_s, por_s};
                end
                default: nxt_rdata = `RCC_RDATA_RST;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read data register
    // ----------------------------------------------------------------
    // zero outside the answer cycle, so a stale value is never taken for a reply
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata_ff <= `RCC_RDATA_RST;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule

/* File: verification/rcc_asserts.sv */
// port checker for the reset cause block
`timescale 1ns/1ps

module rcc_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // sources
    input wire logic sw_reset_req,
    input wire logic wdt_timeout,
    input wire logic pin_reset_n,
    input wire logic por_in,
    // register port
    input wire rcc_pkg::rcc_addr_t reg_addr,
    input wire rcc_pkg::rcc_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire rcc_pkg::rcc_data_t reg_rdata,
    // outputs
    input wire logic sys_reset_out,
    input wire logic debug_reset_out,
    input wire logic irq
);
    import rcc_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // cycles since the last core or watchdog request, saturating so it never wraps into the window
    logic [4:0] quiet_ff;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            quiet_ff <= 5'h00;
        end else if (sw_reset_req || wdt_timeout) begin
            quiet_ff <= 5'h01;
        end else if (quiet_ff != 5'h00 && quiet_ff != 5'h1f) begin
            quiet_ff <= quiet_ff + 5'h01;
        end
    end
    a_rdata_idle_zero: assert property (
        !reg_rd |=> reg_rdata == 32'h0000_0000) else $error("read data outside answer");
    a_rdata_upper_zero: assert property (
        reg_rd |=> reg_rdata[31:4] == 28'h000_0000) else $error("upper read bits set");
    a_request_starts_hold: assert property (
        (sw_reset_req || wdt_timeout) && !por_in && !$past(por_in) && !$past(por_in, 2)
        |=> sys_reset_out) else $error("request did not raise system reset");
    a_hold_stands: assert property (
        quiet_ff >= 5'h01 && quiet_ff <= 5'h10 |-> sys_reset_out)
        else $error("system reset dropped inside hold");
    a_irq_mask_off: assert property (
        reg_wr && reg_addr == 12'h048 && reg_wdata[3:0] == 4'h0 |-> ##2 !irq)
        else $error("irq high with mask cleared");
    a_irq_clear_off: assert property (
        reg_wr && reg_addr == 12'h044 && reg_wdata[3:0] == 4'hf && !sw_reset_req
        && !wdt_timeout && $past(pin_reset_n, 2) && !$past(por_in, 2) |-> ##2 !irq)
        else $error("irq high after status clear");
    a_debug_quiet: assert property (
        !por_in && !$past(por_in) && !$past(por_in, 2) && !$past(por_in, 3)
        && !$past(por_in, 4) |-> !debug_reset_out) else $error("debug reset without power-on");
    a_por_debug: assert property (
        por_in [*6] |-> debug_reset_out) else $error("power-on left debug running");
    c_wdt_hold: cover property (wdt_timeout ##1 sys_reset_out);
    c_read_data: cover property (reg_rd ##1 reg_rdata != 32'h0000_0000);
    c_irq_rise: cover property ($rose(irq));
    c_pin_hold: cover property (!pin_reset_n ##8 sys_reset_out);
endmodule

bind rcc_top rcc_checker u_checker (.core_clk(core_clk), .srst(srst),
    .sw_reset_req(sw_reset_req), .wdt_timeout(wdt_timeout), .por_in(por_in),
    .pin_reset_n(pin_reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sys_reset_out(sys_reset_out),
    .debug_reset_out(debug_reset_out), .irq(irq));

/* File: verification/testbench.sv */
// self-checking bench for the reset cause block
`timescale 1ns/1ps

module testbench;
    import rcc_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic sw_reset_req = 1'b0;
    logic wdt_timeout = 1'b0;
    logic pin_reset_n = 1'b1;
    logic por_in = 1'b1;
    rcc_addr_t reg_addr = 12'h000;
    rcc_data_t reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    rcc_data_t reg_rdata;
    logic sys_reset_out;
    logic debug_reset_out;
    logic irq;
    int n_fail = 0;
    int tests_run = 0;
    int seed = 69;
    int n;
    logic [3:0] cause;
    rcc_data_t rv;

    rcc_top DUT (.core_clk(core_clk), .srst(srst), .sw_reset_req(sw_reset_req),
        .wdt_timeout(wdt_timeout), .pin_reset_n(pin_reset_n), .por_in(por_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sys_reset_out(sys_reset_out),
        .debug_reset_out(debug_reset_out), .irq(irq));

    always #5 core_clk = ~core_clk;

    function automatic logic [3:0] nxt_cause(input logic [3:0] cur, input rcc_data_t clr);
        return cur & ~clr[3:0];
    endfunction

    task automatic chk(input string what, input rcc_data_t exp, input rcc_data_t got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input rcc_addr_t a, input rcc_data_t d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input rcc_addr_t a, output rcc_data_t d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // the clear lands three cycles after its strobe, so pad before the next read
    task automatic clr(input rcc_data_t d);
        wr(12'h040, d);
        cause = nxt_cause(cause, d);
        @(posedge core_clk);
    endtask

    task automatic chk_cause();
        rd(12'h040, rv);
        chk("cause", {28'h000_0000, cause}, rv);
    endtask

    // which is the cause bit: 3 core request, 2 watchdog
    task automatic pulse(input int which);
        @(posedge core_clk);
        if (which == 3) begin
            sw_reset_req <= 1'b1;
        end else begin
            wdt_timeout <= 1'b1;
        end
        @(posedge core_clk);
        sw_reset_req <= 1'b0;
        wdt_timeout <= 1'b0;
        cause[which] = 1'b1;
        #1 n = 0;
        while (sys_reset_out === 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk("hold cycles", 32'h0000_0010, n);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        finish_test();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        repeat (7) @(posedge core_clk);
        por_in <= 1'b0;
        repeat (30) @(posedge core_clk);
        cause = 4'h1;
        chk_cause();
        rd(12'h050, rv);
        chk("unmapped", 32'h0, rv);
        clr(32'h0000_00f0);
        chk_cause();
        clr(32'h0000_0001);
        chk_cause();
        $display("test reset and clear done");
        pulse(3);
        pulse(2);
        chk_cause();
        pin_reset_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        rd(12'h04C, rv);
        chk("source level", 32'h0000_000A, rv);
        pin_reset_n <= 1'b1;
        repeat (30) @(posedge core_clk);
        cause[1] = 1'b1;
        chk_cause();
        chk("debug reset", 32'h0, {31'h0, debug_reset_out});
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        chk_cause();
        $display("test sources done");
        for (int i = 0; i < 24; i++) begin
            rv = $random(seed);
            if (rv[4]) begin
                pulse(rv[5] ? 3 : 2);
            end
            clr(rv);
            chk_cause();
        end
        $display("test random clear done");
        wr(12'h044, 32'h0000_000f);
        wr(12'h048, 32'h0000_0004);
        rd(12'h048, rv);
        chk("mask", 32'h4, rv);
        pulse(2);
        chk("irq", 32'h1, {31'h0, irq});
        wr(12'h048, 32'h0000_0000);
        @(posedge core_clk);
        #1 chk("irq", 32'h0, {31'h0, irq});
        wr(12'h048, 32'h0000_0004);
        @(posedge core_clk);
        #1 chk("irq", 32'h1, {31'h0, irq});
        wr(12'h044, 32'h0000_0004);
        @(posedge core_clk);
        #1 chk("irq", 32'h0, {31'h0, irq});
        rd(12'h044, rv);
        chk("irq status", 32'h0, rv);
        $display("test interrupt done");
        finish_test();
    end
endmodule
